// ### verilog/rcso_consts.vh
`ifndef RCSO_CONSTS_VH
`define RCSO_CONSTS_VH

// register indices on the processor bus
`define RCSO_IDX_STATUS   2'h0
`define RCSO_IDX_ALIAS    2'h1
`define RCSO_IDX_FORCE    2'h2
`define RCSO_IDX_OPTIONS  2'h3

// reset-cause flag positions
`define RCSO_BIT_POWERON  7
`define RCSO_BIT_PIN      6
`define RCSO_BIT_WDOG     5
`define RCSO_BIT_BADOP    4
`define RCSO_BIT_CLKGEN   2
`define RCSO_BIT_LOWV     1

// force-reset bit position
`define RCSO_BIT_FORCE    0

// option field positions
`define RCSO_BIT_WD_EN    7
`define RCSO_BIT_WD_LONG  6
`define RCSO_BIT_STOP_OK  5

// reset values
`define RCSO_CAUSE_POR    8'h82
`define RCSO_OPTS_RESET   3'h6
`define RCSO_ZERO_BYTE    8'h00

// timing counts in bus clock cycles
`define RCSO_WD_SHORT     19'h0_2000
`define RCSO_WD_LONG      19'h4_0000
`define RCSO_HOLD_CYCLES  5'h10

`endif

// ### verilog/rcso_wdog.v
`timescale 1ns/10ps
`include "rcso_consts.vh"

// watchdog counter with two selectable timeout lengths
module rcso_wdog #(
  parameter [18:0] SHORT_CYCLES = `RCSO_WD_SHORT,
  parameter [18:0] LONG_CYCLES  = `RCSO_WD_LONG
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        run,
  input  wire        long_sel,
  input  wire        restart,
  output reg         timeout_reg
);

  reg  [18:0] cnt_reg;   // cycles since last restart
  wire [18:0] limit;     // selected timeout length
  wire        at_end;    // last cycle of the period

  assign limit  = long_sel ? LONG_CYCLES : SHORT_CYCLES;
  assign at_end = (cnt_reg == (limit - 19'h0_0001));

  // count while running; restart or a stopped dog holds zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg     <= 19'h0_0000;
      timeout_reg <= 1'b0;
    end else if (ce) begin
      // restart wins so a service in the last cycle saves the system
      if (restart || !run) begin
        cnt_reg     <= 19'h0_0000;
        timeout_reg <= 1'b0;
      end else if (at_end) begin
        cnt_reg     <= 19'h0_0000;
        timeout_reg <= 1'b1;
      end else begin
        cnt_reg     <= cnt_reg + 19'h0_0001;
        timeout_reg <= 1'b0;
      end
    end
  end

endmodule

// ### verilog/rcso_top.v
// Notes on behaviour
// - debug-forced reset leaves every cause flag clear
// - status write restarts watchdog, flags unchanged
// - power-on sets bits 7 and 1 only
// - low-voltage reset keeps bit 7, sets bit 1
// - other resets flag every active source
// - external pin low sets bit 6
// - watchdog timeout sets bit 5, only when enabled
// - illegal opcode, stop or background sets bit 4
// - clock generator request sets bit 2
// - low-voltage trip with both enables resets
// - force register ignores user writes, reads zero
// - debug host writing bit 0 forces reset
// - options readable, bits 3 and 2 zero
// - options accept only first write after reset
// - watchdog enable option resets to one
// - timeout option selects 2^13 or 2^18 cycles
// - stop option resets zero; stop then illegal
`timescale 1ns/10ps
`include "rcso_consts.vh"

module rcso_top #(
  parameter [18:0] WD_SHORT_CYCLES = `RCSO_WD_SHORT,
  parameter [18:0] WD_LONG_CYCLES  = `RCSO_WD_LONG
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire [1:0] bus_addr,
  input  wire       bus_wr,
  input  wire       bus_rd,
  input  wire       bus_from_debug,
  input  wire [7:0] bus_wdata,
  output reg  [7:0] bus_rdata_reg,
  input  wire       ext_reset_pin_n,
  input  wire       lv_trip_pin,
  input  wire       low_voltage_reset_enable,
  input  wire       low_voltage_stop_enable,
  input  wire       clkgen_reset_req,
  input  wire       unimpl_opcode,
  input  wire       stop_exec,
  input  wire       background_instruction,
  input  wire       background_mode_enable,
  output reg        sys_reset_reg,
  output reg        stop_allowed_reg
);

  // sequencer states
  localparam ST_RUN  = 1'b0;
  localparam ST_HOLD = 1'b1;

  // address match, used by every decoder below
  function hit;
    input [1:0] addr;
    input [1:0] idx;
    begin
      hit = (addr == idx);
    end
  endfunction

  // raw asynchronous pins, index 0 pin reset, index 1 supply trip
  wire [1:0] pin_raw;
  reg  [1:0] sync1_reg;      // first stage, read only by stage two
  reg  [1:0] sync2_reg;      // settled pin levels

  assign pin_raw = {lv_trip_pin, ~ext_reset_pin_n};

  // two-flop synchronisers, one per asynchronous pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (ce) begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  reg       state_reg;       // run or holding system reset
  reg [4:0] hold_cnt_reg;    // cycles spent in reset hold
  reg [7:0] cause_reg;       // reset-cause flags
  reg [2:0] opts_reg;        // enable, long timeout, stop allowed
  reg       opts_lock_reg;   // set after first options write

  wire wd_timeout;           // one-cycle timeout pulse
  wire wd_en;                // watchdog enable option
  wire wd_long;              // long timeout selected
  wire stop_ok;              // stop permission option

  assign wd_en   = opts_reg[2];
  assign wd_long = opts_reg[1];
  assign stop_ok = opts_reg[0];

  // bus strobes, ignored while the processor sits in reset
  wire wr_ok;
  wire wr_status;
  wire wr_force;
  wire wr_opts;

  assign wr_ok     = bus_wr & (state_reg == ST_RUN);
  assign wr_status = wr_ok & (hit(bus_addr, `RCSO_IDX_STATUS) |
                              hit(bus_addr, `RCSO_IDX_ALIAS));
  // only serial debug commands reach the force bit
  assign wr_force  = wr_ok & bus_from_debug &
                     hit(bus_addr, `RCSO_IDX_FORCE);
  assign wr_opts   = wr_ok & hit(bus_addr, `RCSO_IDX_OPTIONS);

  // reset sources as seen in the run state
  wire src_pin;
  wire src_wdog;
  wire src_badop;
  wire src_clkgen;
  wire src_lowv;
  wire src_force;
  wire any_src;

  assign src_pin    = sync2_reg[0];
  // the dog is held idle while disabled, so no pulse then
  assign src_wdog   = wd_timeout & wd_en;
  // stop without permission, or background while disabled
  assign src_badop  = unimpl_opcode |
                      (stop_exec & ~stop_ok) |
                      (background_instruction &
                       ~background_mode_enable);
  assign src_clkgen = clkgen_reset_req;
  assign src_lowv   = sync2_reg[1] & low_voltage_reset_enable &
                      low_voltage_stop_enable;
  assign src_force  = wr_force & bus_wdata[`RCSO_BIT_FORCE];
  assign any_src    = src_pin | src_wdog | src_badop |
                      src_clkgen | src_lowv | src_force;

  // cause value captured at the start of a reset
  reg [7:0] cause_next;

  always @* begin
    cause_next = `RCSO_ZERO_BYTE;
    if (src_lowv) begin
      // supply trip dominates; power-on flag carried over
      cause_next[`RCSO_BIT_POWERON] = cause_reg[`RCSO_BIT_POWERON];
      cause_next[`RCSO_BIT_LOWV]    = 1'b1;
    end else begin
      // each active source flagged, inactive ones cleared
      cause_next[`RCSO_BIT_PIN]    = src_pin;
      cause_next[`RCSO_BIT_WDOG]   = src_wdog;
      cause_next[`RCSO_BIT_BADOP]  = src_badop;
      cause_next[`RCSO_BIT_CLKGEN] = src_clkgen;
      // a forced reset adds no flag of its own
    end
  end

  // reset sequencer and cause capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // power-on: bits 7 and 1, system held in reset
      cause_reg     <= `RCSO_CAUSE_POR;
      state_reg     <= ST_HOLD;
      hold_cnt_reg  <= 5'h00;
      sys_reset_reg <= 1'b1;
    end else if (ce) begin
      case (state_reg)
        ST_RUN: begin
          // a status write never reaches cause_reg
          if (any_src) begin
            cause_reg     <= cause_next;
            state_reg     <= ST_HOLD;
            hold_cnt_reg  <= 5'h00;
            sys_reset_reg <= 1'b1;
          end
        end
        ST_HOLD: begin
          // fixed hold lets every module see the reset
          if (hold_cnt_reg == (`RCSO_HOLD_CYCLES - 5'h01)) begin
            state_reg     <= ST_RUN;
            sys_reset_reg <= 1'b0;
          end else begin
            hold_cnt_reg  <= hold_cnt_reg + 5'h01;
          end
        end
        default: begin
          state_reg     <= ST_HOLD;
          hold_cnt_reg  <= 5'h00;
          sys_reset_reg <= 1'b1;
        end
      endcase
    end
  end

  // write-once options; every reset restores defaults and lock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opts_reg         <= `RCSO_OPTS_RESET;
      opts_lock_reg    <= 1'b0;
      stop_allowed_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_HOLD) begin
        // defaults: watchdog on, long timeout, stop disallowed
        opts_reg         <= `RCSO_OPTS_RESET;
        opts_lock_reg    <= 1'b0;
        stop_allowed_reg <= 1'b0;
      end else if (wr_opts && !opts_lock_reg) begin
        opts_reg <= {bus_wdata[`RCSO_BIT_WD_EN],
                     bus_wdata[`RCSO_BIT_WD_LONG],
                     bus_wdata[`RCSO_BIT_STOP_OK]};
        opts_lock_reg    <= 1'b1;
        stop_allowed_reg <= bus_wdata[`RCSO_BIT_STOP_OK];
      end
    end
  end

  // watchdog: stopped in reset and when disabled
  rcso_wdog #(
    .SHORT_CYCLES (WD_SHORT_CYCLES),
    .LONG_CYCLES  (WD_LONG_CYCLES)
  ) u_wdog (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .run         (wd_en & (state_reg == ST_RUN)),
    .long_sel    (wd_long),
    .restart     (wr_status),
    .timeout_reg (wd_timeout)
  );

  // read data, one cycle after the strobe
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = `RCSO_ZERO_BYTE;
    if (hit(bus_addr, `RCSO_IDX_STATUS) ||
        hit(bus_addr, `RCSO_IDX_ALIAS)) begin
      rd_mux = cause_reg;
    end else if (hit(bus_addr, `RCSO_IDX_OPTIONS)) begin
      // only 7:5 stored; 4:0 including 3 and 2 read zero
      rd_mux[`RCSO_BIT_WD_EN]   = opts_reg[2];
      rd_mux[`RCSO_BIT_WD_LONG] = opts_reg[1];
      rd_mux[`RCSO_BIT_STOP_OK] = opts_reg[0];
    end else begin
      // force register and anything else read as zero
      rd_mux = `RCSO_ZERO_BYTE;
    end
  end

  // read register holds its value between reads
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_reg <= `RCSO_ZERO_BYTE;
    end else if (ce) begin
      if (bus_rd) begin
        bus_rdata_reg <= rd_mux;
      end
    end
  end

endmodule

// ### tb/rcso_checker.sv
`timescale 1ns/10ps
// port-level watch on the reset-cause and options block
module rcso_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       ce,
  input wire [1:0] bus_addr,
  input wire       bus_wr,
  input wire       bus_rd,
  input wire       bus_from_debug,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata_reg,
  input wire       ext_reset_pin_n,
  input wire       clkgen_reset_req,
  input wire       stop_exec,
  input wire       sys_reset_reg,
  input wire       stop_allowed_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // running and clocked: sources are only taken here
  wire run = !sys_reset_reg && ce;
  chk_opts_zero: assert property (ce && bus_rd && bus_addr == 2'h3 |=> bus_rdata_reg[3:2] == 2'h0)
    else $error("options bits 3:2 not zero");
  chk_force_zero: assert property (ce && bus_rd && bus_addr == 2'h2 |=> bus_rdata_reg == 8'h00)
    else $error("force index read not zero");
  chk_debug_reset: assert property (run && bus_wr && bus_from_debug && bus_addr == 2'h2
    && bus_wdata[0] |=> sys_reset_reg)
    else $error("debug force gave no reset");
  chk_stop_default: assert property ($rose(sys_reset_reg) |=> !stop_allowed_reg)
    else $error("stop option not defaulted");
  chk_stop_write: assert property ($rose(stop_allowed_reg) |-> $past(bus_wr)
    && $past(bus_wdata[5]) && $past(bus_addr) == 2'h3)
    else $error("stop option rose without write");
  chk_stop_badop: assert property (run && stop_exec && !stop_allowed_reg |=> sys_reset_reg)
    else $error("illegal stop gave no reset");
  chk_clkgen_rst: assert property (run && clkgen_reset_req |=> sys_reset_reg)
    else $error("clock generator request ignored");
  chk_pin_rst: assert property ((run && !ext_reset_pin_n)[*3] |=> sys_reset_reg)
    else $error("pin low gave no reset");
endmodule

bind rcso_top rcso_checker chk_u (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_from_debug(bus_from_debug), .bus_wdata(bus_wdata),
  .bus_rdata_reg(bus_rdata_reg), .ext_reset_pin_n(ext_reset_pin_n),
  .clkgen_reset_req(clkgen_reset_req), .stop_exec(stop_exec),
  .sys_reset_reg(sys_reset_reg), .stop_allowed_reg(stop_allowed_reg));

// ### tb/rcso_host.sv
`timescale 1ns/10ps
// bus master standing in for user code and the debug host
module rcso_host (
  input  wire       clk,
  output reg  [1:0] bus_addr,
  output reg        bus_wr,
  output reg        bus_rd,
  output reg        bus_from_debug,
  output reg  [7:0] bus_wdata,
  input  wire [7:0] bus_rdata_reg
);
  initial begin
    bus_addr = 2'h0;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_from_debug = 1'h0;
    bus_wdata = 8'h00;
  end
  // one-cycle write; data scrambled after use so stale bytes never match
  task wr(input [1:0] a, input [7:0] v, input dbg);
    begin
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_from_debug <= dbg;
      bus_wr <= 1'h1;
      @(posedge clk);
      bus_wr <= 1'h0;
      bus_wdata <= ~v;
    end
  endtask
  // read answer lands at the edge that takes the strobe
  task rd(input [1:0] a, output [7:0] v);
    begin
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'h1;
      @(posedge clk);
      bus_rd <= 1'h0;
      #1 v = bus_rdata_reg;
    end
  endtask
endmodule

// ### tb/rcso_top_tb.sv
`timescale 1ns/10ps
module rcso_top_tb;
  reg        clk = 1'h0;
  reg        rst_n = 1'h0;
  reg  [5:0] src = 6'h00;  // one bit per reset source
  reg        lv_se = 1'h1; // stop-mode enable of the supply trip
  wire [1:0] bus_addr;
  wire       bus_wr;
  wire       bus_rd;
  wire       bus_from_debug;
  wire [7:0] bus_wdata;
  wire [7:0] bus_rdata_reg;
  wire       sys_reset_reg;
  wire       stop_allowed_reg;
  reg  [7:0] d;
  integer    n_errors = 0;
  integer    total_checks = 0;
  integer    i;
  always #5 clk = ~clk;
  rcso_host host_u (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_from_debug(bus_from_debug), .bus_wdata(bus_wdata), .bus_rdata_reg(bus_rdata_reg));
  // short watchdog counts keep the run brief
  rcso_top #(.WD_SHORT_CYCLES(19'h0_0010), .WD_LONG_CYCLES(19'h0_0040)) dut_u (.clk(clk),
    .rst_n(rst_n), .ce(1'h1), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_from_debug(bus_from_debug), .bus_wdata(bus_wdata), .bus_rdata_reg(bus_rdata_reg),
    .ext_reset_pin_n(~src[0]), .clkgen_reset_req(src[1]), .stop_exec(src[2]),
    .unimpl_opcode(src[3]), .background_instruction(src[4]), .lv_trip_pin(src[5]),
    .low_voltage_reset_enable(1'h1), .low_voltage_stop_enable(lv_se),
    .background_mode_enable(1'h0), .sys_reset_reg(sys_reset_reg),
    .stop_allowed_reg(stop_allowed_reg));
  task chk8(input [8*8-1:0] nm, input [7:0] exp, input [7:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // bounded wait for a system reset level
  task wait_rst(input v);
    begin
      i = 0;
      while (sys_reset_reg !== v && i < 200) begin
        @(posedge clk);
        #1 i = i + 1;
      end
      if (sys_reset_reg !== v) begin
        n_errors = n_errors + 1;
        $display("[FAIL] reset wait expected %h seen timeout", v);
        print_verdict;
      end
    end
  endtask
  task t_por;
    begin
      host_u.rd(2'h0, d);
      chk8("cause", 8'h82, d);
      host_u.rd(2'h3, d);
      chk8("options", 8'hc0, d);
      chk8("stop_ok", 8'h00, {7'h00, stop_allowed_reg});
      $display("test por done");
    end
  endtask
  task t_once;
    begin
      host_u.wr(2'h3, 8'h2c, 1'h0);
      host_u.rd(2'h3, d);
      chk8("options", 8'h20, d);
      host_u.wr(2'h3, 8'hc0, 1'h0);
      host_u.rd(2'h3, d);
      chk8("options", 8'h20, d);
      chk8("stop_ok", 8'h01, {7'h00, stop_allowed_reg});
      $display("test once done");
    end
  endtask
  // supply trip with one enable low must not reset the system
  task t_lv_off;
    begin
      @(posedge clk);
      lv_se <= 1'h0;
      src <= 6'h20;
      repeat (8) @(posedge clk);
      #1 chk8("reset", 8'h00, {7'h00, sys_reset_reg});
      @(posedge clk);
      src <= 6'h00;
      repeat (4) @(posedge clk);
      lv_se <= 1'h1;
      repeat (4) @(posedge clk);
      #1 chk8("reset", 8'h00, {7'h00, sys_reset_reg});
      $display("test trip masked done");
    end
  endtask
  // raise one source for four cycles, then read back the cause byte
  task t_fire(input [2:0] sel, input [7:0] exp);
    begin
      host_u.wr(2'h3, 8'h00, 1'h0);
      @(posedge clk);
      src <= 6'h01 << sel;
      repeat (4) @(posedge clk);
      src <= 6'h00;
      #1 wait_rst(1'h1);
      wait_rst(1'h0);
      host_u.wr(2'h3, 8'h00, 1'h0);
      host_u.rd(2'h0, d);
      chk8("cause", exp, d);
      $display("test source %0d done", sel);
    end
  endtask
  task t_force;
    begin
      host_u.wr(2'h2, 8'h01, 1'h0);
      repeat (3) @(posedge clk);
      chk8("reset", 8'h00, {7'h00, sys_reset_reg});
      host_u.rd(2'h2, d);
      chk8("force", 8'h00, d);
      host_u.wr(2'h2, 8'h01, 1'h1);
      wait_rst(1'h1);
      wait_rst(1'h0);
      host_u.rd(2'h3, d);
      chk8("options", 8'hc0, d);
      host_u.rd(2'h0, d);
      chk8("cause", 8'h00, d);
      $display("test force done");
    end
  endtask
  task t_wdog;
    begin
      host_u.wr(2'h3, 8'h80, 1'h0);
      repeat (2) begin
        host_u.wr(2'h0, 8'h5a, 1'h0);
        repeat (8) @(posedge clk);
        host_u.wr(2'h1, 8'hff, 1'h0);
        repeat (8) @(posedge clk);
      end
      chk8("reset", 8'h00, {7'h00, sys_reset_reg});
      host_u.rd(2'h0, d);
      chk8("cause", 8'h00, d);
      wait_rst(1'h1);
      wait_rst(1'h0);
      host_u.wr(2'h3, 8'h00, 1'h0);
      host_u.rd(2'h0, d);
      chk8("cause", 8'h20, d);
      repeat (100) @(posedge clk);
      chk8("reset", 8'h00, {7'h00, sys_reset_reg});
      $display("test watchdog done");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    #1 wait_rst(1'h0);
    t_por;
    t_once;
    t_lv_off;
    t_fire(3'h5, 8'h82);
    t_fire(3'h0, 8'h40);
    t_fire(3'h1, 8'h04);
    t_fire(3'h2, 8'h10);
    t_fire(3'h3, 8'h10);
    t_fire(3'h4, 8'h10);
    t_force;
    t_wdog;
    print_verdict;
  end
endmodule
